//--- src/sfpi_dev.sv
// Notes on behaviour
// R1 - idle plus sleep and chaining enters sleep
// R2 - clearing run bit stops taking samples
// R3 - standby keeps buffered samples untouched
// R4 - 32 entries, two-bit mode field selects
// R5 - bypass keeps buffer empty, discards samples
// R6 - fifo mode stops storing when full
// R7 - watermark set at level, held until below
// R8 - stream mode overwrites oldest when full
// R9 - trigger raises selected pin, sets seen flag
// R10 - trigger trims to last n, then fills
// R11 - host waits 5 us after trigger
// R12 - re-arm by bypass then trigger mode
// R13 - buffer read moves oldest sample out
// R14 - short read loses rest of sample
// R15 - read ends at 0x38 or frame end
// R16 - fast link: host drops select between reads
// R17 - pins active high, polarity bit inverts
// R18 - mask gates source, route picks pin
// R19 - host configures before enabling interrupts
// R20 - flags latch, cleared by data or cause read
// R21 - overrun on replaced data or full buffer
// R22 - data ready follows available samples
// R23 - inactivity after time below threshold
// R24 - one entry holds three 16-bit axes
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/100ps
module sfpi_dev import sfpi_pkg::*; #(
  parameter int ODR_HZ = 100,                    // samples per second
  parameter int DEPTH  = BUF_DEPTH               // buffer entries
) (
  input  wire logic              SYS_CLK,        // system clock
  input  wire logic              RST,            // async reset, high
  input  wire logic              SMP_VALID,      // one-cycle new sample
  input  wire logic [AXIS_W-1:0] SMP_X,          // x axis value
  input  wire logic [AXIS_W-1:0] SMP_Y,          // y axis value
  input  wire logic [AXIS_W-1:0] SMP_Z,          // z axis value
  input  wire logic [7:0]        SMP_MAG,        // magnitude for inactivity
  input  wire logic              SMP_TRIG,       // one-cycle trigger event
  output logic                   MEASURING,      // sampling run bit
  output logic                   SLEEPING,       // sleep state bit
  sfpi_link_if.dev               LNK             // link to host
);
  localparam int SW = 17;                        // synchronised link bits
  localparam int AW = $clog2(DEPTH);             // pointer width
  localparam int CW = $clog2(DEPTH + 1);         // count width
  localparam int EW = 3 * AXIS_W;                // entry width
  localparam int IW = $clog2(INACT_MAX_S * ODR_HZ + 2);
  localparam logic [SW-1:0] SYNC_IDLE = 17'h0_8000; // idle link levels, select high
  logic [SW-1:0] s1_ff, s2_ff, s3_ff, flt_ff;    // three-stage pin sync
  logic [SW-1:0] nxt_flt;                        // agreed link levels
  logic [7:0]    thr_ff, tim_ff, pwr_ff;         // config registers
  logic [7:0]    ena_ff, map_ff, fmt_ff, bctl_ff;
  logic [7:0]    nxt_pwr;                        // power with sleep set
  logic [7:0]    rdata_ff, rd_byte;              // read path
  logic [7:0]    cause, stat;                    // assembled read bytes
  logic [EW-1:0] mem [DEPTH];                    // sample entries
  logic [EW-1:0] smp_ff;                         // data registers
  logic [AW-1:0] wp_ff, rp_ff;                   // buffer pointers
  logic [CW-1:0] cnt_ff;                         // stored entries
  logic [IW-1:0] icnt_ff;                        // samples below threshold
  logic          loaded_ff, rd_act_ff, trig_ff;  // data, read, trigger state
  logic          ovr_ff, wm_ff, inact_ff;        // latched flags
  logic          irq_a_ff, irq_b_ff;             // pin drivers

  // link decode on agreed levels
  assign nxt_flt = SW'(sfpi_agree(32'(s2_ff), 32'(s3_ff), 32'(flt_ff)));
  wire       f_sck   = nxt_flt[16];
  wire       f_cs_n  = nxt_flt[15];
  wire       f_wr    = nxt_flt[14];
  wire [5:0] f_addr  = nxt_flt[13:8];
  wire [7:0] f_wdata = nxt_flt[7:0];
  wire       beat    = f_sck & ~flt_ff[16] & ~f_cs_n;    // rising link clock
  wire       cs_rise = f_cs_n & ~flt_ff[15];
  wire       wr_beat = beat & f_wr;
  wire       rd_beat = beat & ~f_wr;
  wire       in_data = (f_addr >= ADR_DATA0) && (f_addr <= ADR_DATA5);
  wire       dat_rd  = rd_beat & in_data;
  wire       rd_end  = rd_act_ff & (cs_rise | (beat & ~in_data)); // R15 R14
  wire       cause_rd = rd_beat & (f_addr == ADR_IRQ_CAUSE);

  // mode and measurement
  wire sfpi_mode_t mode = sfpi_mode_t'(bctl_ff[BUF_MODE_LSB +: 2]);   // R4
  wire [CW-1:0] wm    = CW'(bctl_ff[BUF_WM_W-1:0]);
  wire          meas  = pwr_ff[PWR_MEAS_BIT];
  wire          smp_ok = SMP_VALID & meas;                             // R2 R3
  wire          byp   = (mode == MODE_BYPASS);
  wire          strm  = (mode == MODE_STREAM) | ((mode == MODE_TRIG) & ~trig_ff);
  wire          full  = (cnt_ff == CW'(DEPTH));

  // buffer movement
  wire push = smp_ok & ~byp & (strm | ~full);                         // R6 R8
  wire pop  = ~byp & ~loaded_ff & (cnt_ff != '0) & ~rd_act_ff;         // R13
  wire ovwr = push & full & ~pop;                                      // R8
  wire [CW-1:0] cnt_pp = CW'(cnt_ff + CW'(push & ~ovwr) - CW'(pop));
  wire trig_evt = SMP_TRIG & meas & (mode == MODE_TRIG) & ~trig_ff;    // R12
  wire [CW-1:0] drop = (trig_evt && (cnt_pp > wm)) ? CW'(cnt_pp - wm) : '0; // R10
  wire byp_ld = byp & smp_ok;                                          // bypass load
  wire ovr_evt = byp ? (smp_ok & loaded_ff)                            // R21
                     : (smp_ok & (cnt_pp == CW'(DEPTH)));
  wire drdy = loaded_ff | (cnt_ff != '0);                              // R22

  // inactivity timing in sample periods
  wire [IW-1:0] ilim   = IW'(32'(tim_ff) * ODR_HZ);
  wire          quiet  = (SMP_MAG <= thr_ff);
  wire          i_evt  = smp_ok & quiet & (icnt_ff == ilim);           // R23
  wire          go_slp = i_evt & pwr_ff[PWR_AUTO_BIT] & pwr_ff[PWR_LINK_BIT]; // R1

  // interrupt gating and routing
  wire [7:0] src = cause & ena_ff;                                     // R18
  wire pin_a = (|(src & ~map_ff)) | (trig_ff & ~bctl_ff[BUF_TSEL_BIT]); // R9
  wire pin_b = (|(src & map_ff)) | (trig_ff & bctl_ff[BUF_TSEL_BIT]);

  // assemble status bytes
  always_comb begin
    cause = '0;
    cause[CAUSE_DRDY]  = drdy;
    cause[CAUSE_INACT] = inact_ff;
    cause[CAUSE_WM]    = wm_ff;
    cause[CAUSE_OVR]   = ovr_ff;
    stat = '0;
    stat[STAT_TRIG_BIT] = trig_ff;                                     // R9
    stat[CW-1:0] = cnt_ff;
  end

  // register read mux
  always_comb begin
    case (f_addr)
      ADR_INACT_THR: rd_byte = thr_ff;
      ADR_INACT_TIM: rd_byte = tim_ff;
      ADR_PWR:       rd_byte = pwr_ff;
      ADR_IRQ_ENA:   rd_byte = ena_ff;
      ADR_IRQ_MAP:   rd_byte = map_ff;
      ADR_IRQ_CAUSE: rd_byte = cause;
      ADR_FMT:       rd_byte = fmt_ff;
      ADR_BUF_CTL:   rd_byte = bctl_ff;
      ADR_BUF_STAT:  rd_byte = stat;
      default: begin
        if (in_data) begin
          rd_byte = smp_ff[8 * 32'(f_addr - ADR_DATA0) +: 8];
        end else begin
          rd_byte = '0;                        // unmapped reads zero
        end
      end
    endcase
  end

  // sleep set by hardware wins over a write
  always_comb begin
    nxt_pwr = (wr_beat && f_addr == ADR_PWR) ? f_wdata : pwr_ff;
    if (go_slp) begin
      nxt_pwr[PWR_SLEEP_BIT] = 1'b1;                                   // R1
    end
  end

  // link input synchroniser
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      s1_ff  <= SYNC_IDLE;                    // no false select edge after reset
      s2_ff  <= SYNC_IDLE;
      s3_ff  <= SYNC_IDLE;
      flt_ff <= SYNC_IDLE;
    end else begin
      s1_ff  <= {LNK.sck, LNK.cs_n, LNK.wr, LNK.addr, LNK.wdata};
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      flt_ff <= nxt_flt;
    end
  end

  // configuration registers written from the link
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      thr_ff  <= '0;
      tim_ff  <= '0;
      pwr_ff  <= '0;
      ena_ff  <= '0;
      map_ff  <= '0;
      fmt_ff  <= '0;                                                   // R17
      bctl_ff <= '0;
    end else begin
      pwr_ff <= nxt_pwr;
      if (wr_beat) begin
        case (f_addr)
          ADR_INACT_THR: thr_ff  <= f_wdata;
          ADR_INACT_TIM: tim_ff  <= f_wdata;
          ADR_IRQ_ENA:   ena_ff  <= f_wdata;
          ADR_IRQ_MAP:   map_ff  <= f_wdata;
          ADR_FMT:       fmt_ff  <= f_wdata;
          ADR_BUF_CTL:   bctl_ff <= f_wdata;
          default:       ;                    // power, read-only or unmapped
        endcase
      end
    end
  end

  // sample storage, no reset needed
  always_ff @(posedge SYS_CLK) begin
    if (push) begin
      mem[wp_ff] <= {SMP_Z, SMP_Y, SMP_X};                             // R24
    end
  end

  // pointers and count; bypass flushes
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff  <= push ? AW'(wp_ff + 1'b1) : wp_ff;
      rp_ff  <= byp ? wp_ff : AW'(rp_ff + AW'(pop) + AW'(ovwr) + AW'(drop)); // R5
      cnt_ff <= byp ? '0 : CW'(cnt_pp - drop);                         // R5 R10
    end
  end

  // data registers and read tracking
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      smp_ff    <= '0;
      loaded_ff <= 1'b0;
      rd_act_ff <= 1'b0;
      rdata_ff  <= '0;
    end else begin
      if (byp_ld) begin
        smp_ff <= {SMP_Z, SMP_Y, SMP_X};
      end else if (pop) begin
        smp_ff <= mem[rp_ff];                                          // R13
      end
      loaded_ff <= byp_ld | pop | (loaded_ff & ~rd_end);               // R14
      rd_act_ff <= dat_rd | (rd_act_ff & ~rd_end);
      if (rd_beat) begin
        rdata_ff <= rd_byte;
      end
    end
  end

  // latched flags, a set beats a clear
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      trig_ff  <= 1'b0;
      ovr_ff   <= 1'b0;
      wm_ff    <= 1'b0;
      inact_ff <= 1'b0;
      icnt_ff  <= '0;
    end else begin
      trig_ff  <= ~byp & (trig_ff | trig_evt);                         // R9 R12
      ovr_ff   <= ovr_evt | (ovr_ff & ~rd_end);                        // R21 R20
      wm_ff    <= (cnt_ff == wm) | (wm_ff & (cnt_ff > wm));            // R7
      inact_ff <= i_evt | (inact_ff & ~cause_rd);                      // R20
      if (!meas || (smp_ok && !quiet)) begin
        icnt_ff <= '0;
      end else if (smp_ok && icnt_ff <= ilim) begin
        icnt_ff <= IW'(icnt_ff + 1'b1);                                // R23
      end
    end
  end

  // interrupt pins with polarity
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      irq_a_ff <= 1'b0;
      irq_b_ff <= 1'b0;
    end else begin
      irq_a_ff <= pin_a ^ fmt_ff[FMT_INV_BIT];                         // R17
      irq_b_ff <= pin_b ^ fmt_ff[FMT_INV_BIT];
    end
  end

  assign LNK.rdata     = rdata_ff;
  assign LNK.irq_out_a = irq_a_ff;
  assign LNK.irq_out_b = irq_b_ff;
  assign MEASURING     = pwr_ff[PWR_MEAS_BIT];
  assign SLEEPING      = pwr_ff[PWR_SLEEP_BIT];

endmodule // sfpi_dev

//--- src/sfpi_pkg.sv
package sfpi_pkg;
  // buffer geometry
  localparam int BUF_DEPTH   = 32;          // entries in the sample buffer
  localparam int AXIS_W      = 16;          // bits per axis value
  localparam int INACT_MAX_S = 255;         // largest inactivity time in seconds
  // device register offsets on the link
  localparam logic [5:0] ADR_INACT_THR = 6'h25; // inactivity_threshold
  localparam logic [5:0] ADR_INACT_TIM = 6'h26; // inactivity_time
  localparam logic [5:0] ADR_PWR       = 6'h2D; // power_control
  localparam logic [5:0] ADR_IRQ_ENA   = 6'h2E; // irq_enable_mask
  localparam logic [5:0] ADR_IRQ_MAP   = 6'h2F; // irq_route
  localparam logic [5:0] ADR_IRQ_CAUSE = 6'h30; // irq_cause
  localparam logic [5:0] ADR_FMT       = 6'h31; // output_format
  localparam logic [5:0] ADR_DATA0     = 6'h32; // first sample byte
  localparam logic [5:0] ADR_DATA5     = 6'h37; // last sample byte
  localparam logic [5:0] ADR_BUF_CTL   = 6'h38; // buffer_control
  localparam logic [5:0] ADR_BUF_STAT  = 6'h39; // buffer_state
  // field positions
  localparam int PWR_LINK_BIT  = 5;         // activity/inactivity chaining
  localparam int PWR_AUTO_BIT  = 4;         // sleep on idle
  localparam int PWR_MEAS_BIT  = 3;         // sampling run
  localparam int PWR_SLEEP_BIT = 2;         // sleep state
  localparam int FMT_INV_BIT   = 5;         // pins active low
  localparam int BUF_MODE_LSB  = 6;         // mode field 7:6
  localparam int BUF_TSEL_BIT  = 5;         // trigger pin select
  localparam int BUF_WM_W      = 5;         // watermark field 4:0
  localparam int CAUSE_DRDY    = 7;         // data ready
  localparam int CAUSE_INACT   = 3;         // inactivity
  localparam int CAUSE_WM      = 1;         // watermark
  localparam int CAUSE_OVR     = 0;         // overrun
  localparam int STAT_TRIG_BIT = 7;         // trigger_seen_flag
  // buffer modes
  typedef enum logic [1:0] {
    MODE_BYPASS = 2'b00,
    MODE_FIFO   = 2'b01,
    MODE_STREAM = 2'b10,
    MODE_TRIG   = 2'b11
  } sfpi_mode_t;
  // timing
  localparam int CLK_PERIOD_NS = 10;        // system clock period
  localparam int GAP_NS        = 5000;      // least gap before buffer reads
  localparam int GAP_CYC       = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LNK_HALF_CYC  = 16;        // link clock half period in cycles
  // host register offsets on wishbone
  localparam logic [4:0] WB_CMD   = 5'h00;  // command and write byte
  localparam logic [4:0] WB_RD_LO = 5'h04;  // read bytes 0..3
  localparam logic [4:0] WB_RD_HI = 5'h08;  // read bytes 4..7
  localparam logic [4:0] WB_STAT  = 5'h0C;  // busy flag
  localparam int CMD_WR_BIT   = 8;          // 1 = write
  localparam int CMD_LEN_LSB  = 10;         // burst length minus one, 3 bits
  localparam int CMD_DAT_LSB  = 16;         // write byte
  // accept a synchronised change once stages two and three agree
  function automatic logic [31:0] sfpi_agree(input logic [31:0] s2,
                                             input logic [31:0] s3,
                                             input logic [31:0] old);
    return (~(s2 ^ s3) & s2) | ((s2 ^ s3) & old);
  endfunction
endpackage

//--- src/sfpi_link_if.sv
`timescale 1ns/100ps
interface sfpi_link_if;
  logic       sck;       // link clock from host
  logic       cs_n;      // transfer frame, active low
  logic       wr;        // beat direction, 1 = write
  logic [5:0] addr;      // register address of the beat
  logic [7:0] wdata;     // write byte
  logic [7:0] rdata;     // read byte from device
  logic       irq_out_a; // first interrupt pin
  logic       irq_out_b; // second interrupt pin
  modport dev  (input sck, cs_n, wr, addr, wdata, output rdata, irq_out_a, irq_out_b);
  modport host (output sck, cs_n, wr, addr, wdata, input rdata, irq_out_a, irq_out_b);
endinterface

//--- src/sfpi_host.sv
`timescale 1ns/100ps
module sfpi_host import sfpi_pkg::*; #(
  parameter int HALF = LNK_HALF_CYC,              // link half period
  parameter int GAP  = GAP_CYC                    // gap after transfers
) (
  input  wire logic        SYS_CLK,               // system clock
  input  wire logic        RST,                   // async reset, high
  input  wire logic        CYC_I,                 // wishbone cycle
  input  wire logic        STB_I,                 // wishbone strobe
  input  wire logic        WE_I,                  // wishbone write
  input  wire logic [4:0]  ADR_I,                 // byte address
  input  wire logic [3:0]  SEL_I,                 // byte enables
  input  wire logic [31:0] DAT_I,                 // write data
  output logic      [31:0] DAT_O,                 // read data
  output logic             ACK_O,                 // one-cycle ack
  sfpi_link_if.host        LNK                    // link to device
);
  localparam int TW = $clog2(GAP + HALF + 1);     // timer width
  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_GAP} sfpi_hst_t;

  sfpi_hst_t   st_ff;                             // link sequencer
  logic [TW-1:0] tmr_ff;                          // phase and gap timer
  logic [9:0]  s1_ff, s2_ff, s3_ff, flt_ff;       // rdata and pin sync
  logic [9:0]  nxt_flt;                           // agreed levels
  logic [31:0] cmd_ff, nxt_cmd;                   // command register
  logic [63:0] rbuf_ff;                           // read bytes
  logic [2:0]  beat_ff;                           // beat index
  logic [5:0]  addr_ff;                           // beat address
  logic        go_ff, ack_ff, sck_ff, cs_n_ff;    // control state
  logic [31:0] dat_ff;                            // read data register

  // bus decode
  wire req   = CYC_I & STB_I & ~ack_ff;
  wire busy  = go_ff | (st_ff != H_IDLE);
  wire cmd_w = req & WE_I & (ADR_I == WB_CMD) & ~busy;
  wire [31:0] rd_mux = (ADR_I == WB_RD_LO) ? rbuf_ff[31:0] :
                       (ADR_I == WB_RD_HI) ? rbuf_ff[63:32] :
                       (ADR_I == WB_STAT)  ? {31'h0000_0000, busy} : 32'h0000_0000;

  // link-side decode
  assign nxt_flt = 10'(sfpi_agree(32'(s2_ff), 32'(s3_ff), 32'(flt_ff)));
  wire irq_chg  = |(nxt_flt[9:8] ^ flt_ff[9:8]);  // R11
  wire [2:0] len = cmd_ff[CMD_LEN_LSB +: 3];
  wire ph_end   = (tmr_ff == TW'(HALF - 1));

  // byte-enable merge for the command word
  always_comb begin
    nxt_cmd = cmd_ff;
    for (int i = 0; i < 4; i++) begin
      if (SEL_I[i]) begin
        nxt_cmd[8 * i +: 8] = DAT_I[8 * i +: 8];
      end
    end
  end

  // wishbone slave, ack one cycle after request
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ack_ff <= 1'b0;
      dat_ff <= '0;
      cmd_ff <= '0;
      go_ff  <= 1'b0;
    end else begin
      ack_ff <= req;
      if (req && !WE_I) begin
        dat_ff <= rd_mux;
      end
      if (cmd_w) begin
        cmd_ff <= nxt_cmd;
      end
      go_ff <= cmd_w | (go_ff & ~((st_ff == H_IDLE) & ~irq_chg)); // kept across an irq gap
    end
  end

  // synchroniser for device outputs
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      s1_ff  <= '0;
      s2_ff  <= '0;
      s3_ff  <= '0;
      flt_ff <= '0;
    end else begin
      s1_ff  <= {LNK.irq_out_b, LNK.irq_out_a, LNK.rdata};
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      flt_ff <= nxt_flt;
    end
  end

  // link sequencer: frame, beats, closing gap
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      st_ff   <= H_IDLE;
      tmr_ff  <= '0;
      beat_ff <= '0;
      addr_ff <= '0;
      sck_ff  <= 1'b0;
      cs_n_ff <= 1'b1;
      rbuf_ff <= '0;
    end else begin
      tmr_ff <= TW'(tmr_ff + 1'b1);
      case (st_ff)
        H_IDLE: begin
          tmr_ff <= '0;
          if (irq_chg) begin
            st_ff <= H_GAP;                        // R11
          end else if (go_ff) begin
            st_ff   <= H_LOW;
            cs_n_ff <= 1'b0;
            addr_ff <= cmd_ff[5:0];
            beat_ff <= '0;
            rbuf_ff <= '0;
          end
        end
        H_LOW: begin
          if (ph_end) begin
            st_ff  <= H_HIGH;
            sck_ff <= 1'b1;
            tmr_ff <= '0;
          end
        end
        H_HIGH: begin
          if (ph_end) begin
            rbuf_ff[8 * beat_ff +: 8] <= flt_ff[7:0];
            sck_ff <= 1'b0;
            tmr_ff <= '0;
            if (beat_ff == len) begin
              st_ff   <= H_GAP;
              cs_n_ff <= 1'b1;                     // R16 R14
            end else begin
              st_ff   <= H_LOW;
              beat_ff <= 3'(beat_ff + 1'b1);
              addr_ff <= 6'(addr_ff + 1'b1);
            end
          end
        end
        H_GAP: begin
          if (irq_chg) begin
            tmr_ff <= '0;                          // R11
          end else if (tmr_ff == TW'(GAP - 1)) begin
            st_ff <= H_IDLE;                       // R15
          end
        end
        default: st_ff <= H_IDLE;
      endcase
    end
  end

  assign ACK_O     = ack_ff;
  assign DAT_O     = dat_ff;
  assign LNK.sck   = sck_ff;
  assign LNK.cs_n  = cs_n_ff;
  assign LNK.addr  = addr_ff;
  assign LNK.wr    = cmd_ff[CMD_WR_BIT];
  assign LNK.wdata = cmd_ff[CMD_DAT_LSB +: 8];

endmodule // sfpi_host

//--- tb/sfpi_link_sva.sv
`timescale 1ns/100ps
// framing checks on the wires between host and device
module sfpi_link_sva (
  input wire logic       SYS_CLK, // system clock
  input wire logic       RST,     // async reset, high
  input wire logic       sck,     // link clock
  input wire logic       cs_n,    // frame select, low
  input wire logic       wr,      // beat direction
  input wire logic [5:0] addr,    // beat address
  input wire logic [7:0] wdata    // write byte
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  a_sck_in_frame: assert property (sck |-> !cs_n)
    else $error("link clock high outside a frame");
  a_beat_stable: assert property (sck && $past(sck) |-> $stable({wr, addr, wdata}))
    else $error("beat fields moved while clock high");
  a_high_phase: assert property ($rose(sck) |-> ##16 $fell(sck))
    else $error("clock high phase has wrong length");
  a_low_phase: assert property ($fell(sck) && !cs_n |-> ##16 $rose(sck))
    else $error("clock low phase has wrong length");
  a_lead_in: assert property ($fell(cs_n) |-> ##16 $rose(sck))
    else $error("first clock rise not one half period after select");
  a_frame_end: assert property ($rose(cs_n) |-> $fell(sck))
    else $error("select released away from last clock fall");
  a_read_gap: assert property ($rose(cs_n) |=> cs_n [*8])
    else $error("gap after frame too short");
  a_addr_step: assert property ($fell(sck) && !cs_n |-> addr == $past(addr) + 6'h01)
    else $error("burst address did not step by one");
endmodule // sfpi_link_sva

//--- tb/tb_top.sv
`timescale 1ns/100ps
module tb_top import sfpi_pkg::*; ;
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        sv = 1'b0, trg = 1'b0, ack, meas, slp; // sample strobes and status
  logic [4:0]  adr = 5'h00;                          // wishbone address
  logic [31:0] dat = 32'h0000_0000, dq, rd;          // wishbone data
  logic [31:0] seed = 32'h265c_ec31;                 // xorshift state
  logic [15:0] sx = 16'h0000, sy = 16'h0000, sz = 16'h0000;
  logic [7:0]  mag = 8'h00;                          // sample magnitude
  logic [63:0] r;                                    // bytes of last link read
  logic [47:0] h[$];                                 // samples sent, as {z,y,x}
  int          failures = 0, samples_checked = 0, cyc_n = 0;
  sfpi_link_if lnk();
  sfpi_host #(.HALF(16), .GAP(40)) sfpi_host_i (.SYS_CLK(clk), .RST(rst), .CYC_I(cyc),
    .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hf), .DAT_I(dat), .DAT_O(dq), .ACK_O(ack),
    .LNK(lnk));
  sfpi_dev #(.ODR_HZ(1)) sfpi_dev_i (.SYS_CLK(clk), .RST(rst), .SMP_VALID(sv), .SMP_X(sx),
    .SMP_Y(sy), .SMP_Z(sz), .SMP_MAG(mag), .SMP_TRIG(trg), .MEASURING(meas),
    .SLEEPING(slp), .LNK(lnk));
  sfpi_link_sva sfpi_link_sva_i (.SYS_CLK(clk), .RST(rst), .sck(lnk.sck), .cs_n(lnk.cs_n),
    .wr(lnk.wr), .addr(lnk.addr), .wdata(lnk.wdata));
  // clock and hang guard
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 60000) begin
      failures++;
      test_done();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string n, input logic [47:0] e, input logic [47:0] s);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done();
    if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do @(posedge clk); while (ack !== 1'b1);
    rd = dq;
    {cyc, stb} <= 2'b00;
  endtask
  // one link frame through the host, then fetch the read bytes
  task automatic op(input logic w, input logic [5:0] a, input int n, input logic [7:0] b);
    logic [31:0] c;
    c = {8'h00, b, 3'h0, 3'(n - 1), 1'b0, w, 2'b00, a};
    wb(1'b1, WB_CMD, c);
    do wb(1'b0, WB_STAT, 32'h0000_0000); while (rd[0] !== 1'b0);
    wb(1'b0, WB_RD_LO, 32'h0000_0000);
    r[31:0] = rd;
    wb(1'b0, WB_RD_HI, 32'h0000_0000);
    r[63:32] = rd;
  endtask
  // random samples with a given magnitude
  task automatic smp(input int n, input logic [7:0] m);
    logic [47:0] v;
    repeat (n) begin
      v = {16'(xs()), 16'(xs()), 16'(xs())};
      h.push_back(v);
      @(posedge clk);
      {sv, sz, sy, sx, mag} <= {1'b1, v, m};
      @(posedge clk);
      sv <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  task automatic trig();
    @(posedge clk);
    trg <= 1'b1;
    @(posedge clk);
    trg <= 1'b0;
    repeat (600) @(posedge clk);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    chk("pins", 0, {lnk.irq_out_a, lnk.irq_out_b});
    op(1, ADR_PWR, 1, 8'h08);
    chk("run", 1, meas);
    op(1, ADR_BUF_CTL, 1, 8'h44);
    smp(34, 8'hff);
    op(0, ADR_IRQ_CAUSE, 1, 8'h00);
    chk("cause", 8'h83, r[7:0]);
    op(0, ADR_BUF_STAT, 1, 8'h00);
    chk("count", 32, r[5:0]);
    op(0, ADR_DATA0, 6, 8'h00);
    chk("data", h[0], r[47:0]);
    op(0, ADR_DATA0, 2, 8'h00);
    chk("x", h[1][15:0], r[15:0]);
    op(0, ADR_DATA0, 6, 8'h00);
    chk("data", h[2], r[47:0]);
    op(1, ADR_PWR, 1, 8'h00);
    chk("run", 0, meas);
    smp(3, 8'hff);
    op(0, ADR_DATA0, 6, 8'h00);
    chk("data", h[3], r[47:0]);
    op(0, ADR_BUF_STAT, 1, 8'h00);
    chk("count", 28, r[5:0]);
    op(1, ADR_PWR, 1, 8'h08);
    op(1, ADR_BUF_CTL, 1, 8'h00);
    smp(2, 8'hff);
    op(0, ADR_BUF_STAT, 1, 8'h00);
    chk("count", 0, r[5:0]);
    h.delete();
    op(1, ADR_BUF_CTL, 1, 8'h80);
    smp(40, 8'hff);
    op(0, ADR_BUF_STAT, 1, 8'h00);
    chk("count", 32, r[5:0]);
    op(0, ADR_DATA0, 6, 8'h00);
    op(0, ADR_DATA0, 6, 8'h00);
    chk("data", h[8], r[47:0]);
    op(1, ADR_BUF_CTL, 1, 8'hc2);
    smp(5, 8'hff);
    trig();
    chk("pins", 2'b10, {lnk.irq_out_a, lnk.irq_out_b});
    op(0, ADR_BUF_STAT, 1, 8'h00);
    chk("seen", 1, r[7]);
    chk("count", 2, r[5:0]);
    op(1, ADR_BUF_CTL, 1, 8'h00);
    chk("pins", 2'b00, {lnk.irq_out_a, lnk.irq_out_b});
    op(1, ADR_BUF_CTL, 1, 8'he2);
    smp(3, 8'hff);
    trig();
    chk("pins", 2'b01, {lnk.irq_out_a, lnk.irq_out_b});
    smp(2, 8'hff);
    trig();
    op(0, ADR_BUF_STAT, 1, 8'h00);
    chk("count", 4, r[5:0]);
    op(1, ADR_FMT, 1, 8'h20);
    chk("pins", 2'b10, {lnk.irq_out_a, lnk.irq_out_b});
    op(1, ADR_IRQ_ENA, 1, 8'h80);
    chk("pins", 2'b00, {lnk.irq_out_a, lnk.irq_out_b});
    op(1, ADR_IRQ_ENA, 1, 8'h00);
    op(1, ADR_IRQ_MAP, 1, 8'h80);
    op(1, ADR_IRQ_ENA, 1, 8'h80);
    chk("pins", 2'b10, {lnk.irq_out_a, lnk.irq_out_b});
    op(1, ADR_INACT_THR, 1, 8'h10);
    op(1, ADR_INACT_TIM, 1, 8'h02);
    op(1, ADR_PWR, 1, 8'h38);
    smp(4, 8'h00);
    chk("sleep", 1, slp);
    op(0, ADR_IRQ_CAUSE, 1, 8'h00);
    chk("idle", 1, r[3]);
    op(0, ADR_IRQ_CAUSE, 1, 8'h00);
    chk("idle", 0, r[3]);
    test_done();
  end
endmodule // tb_top
